// ===== vfbm_pkg.sv
// vfbm_pkg: constants, register map and carrier types for the valve feedback bitmap block
// assumes a 25 MHz system clock and a 32-bit classic wishbone register bus
package vfbm_pkg;

   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned FLASH_MS      = 250;
   localparam int unsigned FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] STATUS_OFS    = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;

   // control register fields
   localparam int unsigned CTRL_US_BIT     = 0;
   localparam int unsigned CTRL_NC_BIT     = 1;
   localparam int unsigned CTRL_FAULT_BIT  = 2;

   // status register fields
   localparam int unsigned ST_FB_LSB       = 0;
   localparam int unsigned ST_US_ACT_BIT   = 5;
   localparam int unsigned ST_THREE_BIT    = 6;
   localparam int unsigned ST_SEL_LSB      = 8;

   // interrupt events
   localparam int unsigned IRQ_W           = 3;
   localparam int unsigned IRQ_FB_BIT      = 0;
   localparam int unsigned IRQ_FAULT_BIT   = 1;
   localparam int unsigned IRQ_US_BIT      = 2;

   // reset values
   localparam logic [2:0]       CTRL_RST     = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // select presses that arm the mapping toggle
   localparam logic [2:0] SEL_ARM = 3'h5;

   // edges after reset release before the synchronised strap holds the pin
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   typedef struct packed {
      logic all_closed_feedback;
      logic main_open;
      logic upper_fb;
      logic lower_fb;
      logic valve_state;
   } vfbm_fb_t;

   localparam vfbm_fb_t FB_RST = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

   typedef struct packed {
      logic main_solenoid;
      logic upper_lift_solenoid;
      logic lower_push_solenoid;
   } vfbm_cmd_t;

   typedef struct packed {
      logic upper_closed;
      logic upper_lifted;
      logic lower_closed;
      logic lower_open;
      logic lower_push;
   } vfbm_seat_t;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_COUNT = 2'b01,
      KEY_ARMED = 2'b11
   } vfbm_key_t;

endpackage

// ===== vfbm_sync.sv
// vfbm_sync: two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels and clk_i is the system clock
module vfbm_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

// ===== vfbm_top.sv
// vfbm_top: maps solenoid commands and seat positions onto plc feedback outputs
// assumes pins are asynchronous to clk_i and a classic wishbone master on the bus
//
// How it works
// - one-solenoid unit: idle gives closed=1, main on gives open=1, state high
// - three-solenoid default: idle with both seats closed gives only all-closed
// - default: main on and lower seat open gives only main-open
// - default: upper lift on, upper lifted, lower closed gives only upper-lift
// - default: lower push on, lower pushed, upper closed gives only lower-push
// - us mapping exists only on the three-solenoid unit, for all interfaces
// - five select presses arm the toggle, enter flips it; also a bus parameter
// - us mapping is off after reset and may be enabled at any time
// - restore to defaults leaves the us mapping setting untouched
// - us mapping turns upper and lower outputs into seat-closed indications
// - us idle both closed: all-closed, upper and lower closed high, main low
// - us: main gives main-open, upper lift gives lower, lower push gives upper
// - us result ignores whether the seat-lift sensor is normally open or closed
// - any fail-safe fault pulls the valve-state line low
//
// Local design decisions: the Wishbone register port and the register addresses.
module vfbm_top
   import vfbm_pkg::*;
#(
   parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // plc commands and sensors (pins)
   input  wire logic        command_bit_one_i,
   input  wire logic        command_bit_two_i,
   input  wire logic        command_bit_three_i,
   input  wire logic        upper_closed_i,
   input  wire logic        upper_lift_sense_i,
   input  wire logic        lower_closed_i,
   input  wire logic        lower_open_i,
   input  wire logic        lower_push_i,
   input  wire logic        fault_i,
   input  wire logic        three_solenoid_i,
   input  wire logic        select_key_i,
   input  wire logic        enter_key_i,
   input  wire logic        restore_i,
   // plc feedback
   output logic             feedback_bit_zero_o,
   output logic             feedback_bit_one_o,
   output logic             feedback_bit_two_o,
   output logic             feedback_bit_three_o,
   output logic             valve_state_o,
   output logic             led8_flash_o,
   output logic             irq_o
);

   localparam int unsigned NPIN = 13;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   assign pin_raw = {command_bit_one_i, command_bit_two_i, command_bit_three_i,
                     upper_closed_i, upper_lift_sense_i, lower_closed_i,
                     lower_open_i, lower_push_i, fault_i, three_solenoid_i,
                     select_key_i, enter_key_i, restore_i};
   vfbm_sync #(.W(NPIN)) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (pin_raw),
      .q_o       (pin_s)
   );
   vfbm_cmd_t  cmd;
   vfbm_seat_t seat;
   logic       fault_s;
   logic       three_s;
   logic       sel_s;
   logic       ent_s;
   logic       rst_s;
   assign cmd.main_solenoid       = pin_s[12];
   assign cmd.upper_lift_solenoid = pin_s[11];
   assign cmd.lower_push_solenoid = pin_s[10];
   assign seat.upper_closed       = pin_s[9];
   assign seat.lower_closed       = pin_s[7];
   assign seat.lower_open         = pin_s[6];
   assign seat.lower_push         = pin_s[5];
   assign fault_s                 = pin_s[4];
   assign three_s                 = pin_s[3];
   assign sel_s                   = pin_s[2];
   assign ent_s                   = pin_s[1];
   assign rst_s                   = pin_s[0];
   // configuration and state
   logic [2:0]       ctrl;
   logic             three_sol;
   logic             strap_taken;
   logic [1:0]       strap_wait;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   vfbm_fb_t         fb;
   vfbm_key_t        key_st;
   logic [2:0]       sel_cnt;
   logic             sel_d;
   logic             ent_d;
   logic             rst_d;
   logic             fault_d;
   logic [22:0]      flash_cnt;
   logic             flash;
   logic us_en;
   logic sensor_nc;
   logic sw_fault;
   assign us_en     = ctrl[CTRL_US_BIT];
   assign sensor_nc = ctrl[CTRL_NC_BIT];
   assign sw_fault  = ctrl[CTRL_FAULT_BIT];
   // normally-closed sensor reads inverted; us mapping does not use it
   assign seat.upper_lifted = pin_s[8] ^ sensor_nc;
   // option only takes effect on a three-solenoid unit
   logic us_act;
   assign us_act = us_en & three_sol;
   // key and restore edges
   logic sel_rise;
   logic ent_rise;
   logic rst_rise;
   assign sel_rise = sel_s & ~sel_d;
   assign ent_rise = ent_s & ~ent_d;
   assign rst_rise = rst_s & ~rst_d;
   logic key_toggle;
   assign key_toggle = ent_rise & (key_st == KEY_ARMED) & three_sol;
   // bus decode
   logic bus_req;
   logic bus_wr;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_istat;
   logic hit_imask;
   assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
   assign hit_ctrl  = (wb_adr_i == CTRL_OFS);
   assign hit_stat  = (wb_adr_i == STATUS_OFS);
   assign hit_istat = (wb_adr_i == IRQ_STAT_OFS);
   assign hit_imask = (wb_adr_i == IRQ_MASK_OFS);
   // feedback mapping
   logic none_active;
   logic both_closed;
   assign none_active = ~(cmd.main_solenoid | cmd.upper_lift_solenoid | cmd.lower_push_solenoid);
   assign both_closed = seat.upper_closed & seat.lower_closed;
   vfbm_fb_t next_fb;
   always_comb begin
      next_fb = FB_RST;
      if (!three_sol) begin
         next_fb.all_closed_feedback = ~cmd.main_solenoid;
         next_fb.main_open           = cmd.main_solenoid;
         next_fb.upper_fb            = 1'b0;
         next_fb.lower_fb            = 1'b0;
      end else if (us_act) begin
         next_fb.all_closed_feedback = none_active & both_closed;
         next_fb.main_open           = cmd.main_solenoid & seat.lower_open;
         next_fb.upper_fb            = seat.upper_closed;
         next_fb.lower_fb            = seat.lower_closed;
      end else begin
         next_fb.all_closed_feedback = none_active & both_closed;
         next_fb.main_open           = cmd.main_solenoid & seat.lower_open;
         next_fb.upper_fb            = cmd.upper_lift_solenoid & seat.upper_lifted
                                       & seat.lower_closed;
         next_fb.lower_fb            = cmd.lower_push_solenoid & seat.lower_push
                                       & seat.upper_closed;
      end
      next_fb.valve_state = ~(fault_s | sw_fault);
   end

   // interrupt events; set wins over a same-cycle clear
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_clr;
   logic [IRQ_W-1:0] next_irq_stat;
   assign irq_ev[IRQ_FB_BIT]    = (next_fb != fb);
   assign irq_ev[IRQ_FAULT_BIT] = (fault_s | sw_fault) & ~fault_d;
   assign irq_ev[IRQ_US_BIT]    = key_toggle;
   assign irq_clr       = (bus_wr & hit_istat) ? wb_dat_i[IRQ_W-1:0] : '0;
   assign next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
   // registered feedback, one update per cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fb <= FB_RST;
      end else begin
         fb <= next_fb;
      end
   end

   assign feedback_bit_zero_o  = fb.all_closed_feedback;
   assign feedback_bit_one_o   = fb.main_open;
   assign feedback_bit_two_o   = fb.upper_fb;
   assign feedback_bit_three_o = fb.lower_fb;
   assign valve_state_o        = fb.valve_state;
   // variant strap caught once; the sync flops read zero until refilled after reset
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         three_sol   <= 1'b0;
         strap_taken <= 1'b0;
         strap_wait  <= 2'h0;
      end else if (strap_wait != STRAP_WAIT) begin
         strap_wait  <= strap_wait + 2'h1;
      end else if (!strap_taken) begin
         three_sol   <= three_s;
         strap_taken <= 1'b1;
      end
   end

   // control: us bit off from reset, restore keeps it
   logic [2:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      if (bus_wr && hit_ctrl) begin
         next_ctrl = wb_dat_i[2:0];
      end
      if (key_toggle) begin
         next_ctrl[CTRL_US_BIT] = ~ctrl[CTRL_US_BIT];
      end
      if (rst_rise) begin
         next_ctrl = {CTRL_RST[2:1], next_ctrl[CTRL_US_BIT]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl <= CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // key sequencer: five select presses arm, enter toggles, restore clears
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         key_st  <= KEY_IDLE;
         sel_cnt <= 3'h0;
      end else if (rst_rise || ent_rise) begin
         key_st  <= KEY_IDLE;
         sel_cnt <= 3'h0;
      end else begin
         case (key_st)
            KEY_IDLE: begin
               if (sel_rise) begin
                  key_st  <= KEY_COUNT;
                  sel_cnt <= 3'h1;
               end
            end
            KEY_COUNT: begin
               if (sel_rise) begin
                  sel_cnt <= sel_cnt + 3'h1;
                  if (sel_cnt + 3'h1 == SEL_ARM) begin
                     key_st <= KEY_ARMED;
                  end
               end
            end
            KEY_ARMED: begin
               // a sixth press wraps to a fresh count
               if (sel_rise) begin
                  key_st  <= KEY_COUNT;
                  sel_cnt <= 3'h1;
               end
            end
            default: begin
               key_st  <= KEY_IDLE;
               sel_cnt <= 3'h0;
            end
         endcase
      end
   end

   // indicator flash while armed; divider gives the toggle enable
   logic flash_tick;
   assign flash_tick = (flash_cnt == 23'(FLASH_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flash_cnt    <= 23'h0;
         flash        <= 1'b0;
         led8_flash_o <= 1'b0;
      end else begin
         flash_cnt    <= flash_tick ? 23'h0 : flash_cnt + 23'h1;
         if (flash_tick) begin
            flash <= ~flash;
         end
         led8_flash_o <= (key_st == KEY_ARMED) & flash;
      end
   end

   // edge history
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sel_d   <= 1'b0;
         ent_d   <= 1'b0;
         rst_d   <= 1'b0;
         fault_d <= 1'b0;
      end else begin
         sel_d   <= sel_s;
         ent_d   <= ent_s;
         rst_d   <= rst_s;
         fault_d <= fault_s | sw_fault;
      end
   end

   // interrupts; restore also clears the mask
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_stat <= '0;
         irq_mask <= IRQ_MASK_RST;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (rst_rise) begin
            irq_mask <= IRQ_MASK_RST;
         end else if (bus_wr && hit_imask) begin
            irq_mask <= wb_dat_i[IRQ_W-1:0];
         end
         irq_o <= |(next_irq_stat & irq_mask);
      end
   end

   // read mux; unmapped offsets read zero
   logic [31:0] rd_data;
   assign rd_data = hit_ctrl  ? {29'h0, ctrl} :
                    hit_stat  ? {21'h0, sel_cnt, 1'b0, three_sol, us_act, fb} :
                    hit_istat ? {29'h0, irq_stat} :
                    hit_imask ? {29'h0, irq_mask} : 32'h0;

   // single-cycle ack the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h0;
      end
   end

endmodule

// ===== vfbm_props.sv
// vfbm_props: port-level assertions for vfbm_top
// assumes one clock domain with the sync active-high reset of the top module
module vfbm_props
   import vfbm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic        command_bit_one_i,
   input  wire logic        command_bit_two_i,
   input  wire logic        command_bit_three_i,
   input  wire logic        upper_closed_i,
   input  wire logic        upper_lift_sense_i,
   input  wire logic        lower_closed_i,
   input  wire logic        lower_open_i,
   input  wire logic        lower_push_i,
   input  wire logic        fault_i,
   input  wire logic        three_solenoid_i,
   input  wire logic        select_key_i,
   input  wire logic        enter_key_i,
   input  wire logic        restore_i,
   input  wire logic        feedback_bit_zero_o,
   input  wire logic        feedback_bit_one_o,
   input  wire logic        feedback_bit_two_o,
   input  wire logic        feedback_bit_three_o,
   input  wire logic        valve_state_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // windows are long enough to cover two sync flops, edge detect and output flop
   wire logic [12:0] pins_w = {command_bit_one_i, command_bit_two_i, command_bit_three_i,
      upper_closed_i, upper_lift_sense_i, lower_closed_i, lower_open_i, lower_push_i,
      fault_i, three_solenoid_i, select_key_i, enter_key_i, restore_i};
   wire logic [4:0]  fb_w = {feedback_bit_zero_o, feedback_bit_one_o, feedback_bit_two_o,
      feedback_bit_three_o, valve_state_o};
   wire logic        any_cmd_w = command_bit_one_i | command_bit_two_i | command_bit_three_i;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_fault_low: assert property (fault_i [*6] |-> !valve_state_o)
      else $error("valve state high during fault");
   a_main_needs_cmd: assert property ((!command_bit_one_i) [*5] |-> !feedback_bit_one_o)
      else $error("main open without main command");
   a_closed_idle: assert property (any_cmd_w [*5] |-> !feedback_bit_zero_o)
      else $error("all closed shown with a command active");
   a_open_closed_excl: assert property (feedback_bit_one_o |-> !feedback_bit_zero_o)
      else $error("open and closed shown together");
   a_fb_steady: assert property (($stable(pins_w) && !wb_cyc_i) [*8] |-> $stable(fb_w))
      else $error("feedback moved with steady inputs");
endmodule

bind vfbm_top vfbm_props vfbm_props_i (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
   .wb_ack_o, .command_bit_one_i, .command_bit_two_i, .command_bit_three_i, .upper_closed_i,
   .upper_lift_sense_i, .lower_closed_i, .lower_open_i, .lower_push_i, .fault_i,
   .three_solenoid_i, .select_key_i, .enter_key_i, .restore_i, .feedback_bit_zero_o,
   .feedback_bit_one_o, .feedback_bit_two_o, .feedback_bit_three_o, .valve_state_o);

// ===== vfbm_plc.sv
// vfbm_plc: plc command outputs and a valve whose seats follow them
// assumes commands come from the bench; seats read all-off while travelling
module vfbm_plc
   import vfbm_pkg::*;
(
   input  wire logic       clk_i,
   input  wire vfbm_cmd_t  cmd_i,
   input  wire logic       nc_i,
   input  wire logic [3:0] travel_i,
   output vfbm_cmd_t       cmd_o,
   output vfbm_seat_t      seat_o,
   output logic            lift_sense_o
);
   timeunit 1ns;
   timeprecision 1ps;
   vfbm_cmd_t  cmd_q  = '0;
   logic [3:0] moving = 4'h0;
   vfbm_seat_t pos;

   // travel time lets the bench play a prompt or a slow valve
   always @(posedge clk_i) begin
      cmd_q <= cmd_i;
      if (cmd_i != cmd_q) moving <= travel_i;
      else if (moving != 4'h0) moving <= moving - 4'h1;
   end

   always_comb begin
      pos = '0;
      if (moving == 4'h0) begin
         case (cmd_q)
            3'h0:    pos = 5'h14; // both seats closed
            3'h4:    pos = 5'h02; // lower seat open, upper not closed
            3'h2:    pos = 5'h0c; // upper lifted, lower closed
            3'h1:    pos = 5'h11; // lower pushed, upper closed
            default: pos = '0;
         endcase
      end
   end

   assign cmd_o        = cmd_q;
   assign seat_o       = pos;
   assign lift_sense_o = pos.upper_lifted ^ nc_i; // raw level flips for a nc sensor
endmodule

// ===== vfbm_top_test.sv
// vfbm_top_test: register bus and feedback mapping tests for vfbm_top
// assumes vfbm_plc drives command and seat pins; flash period shortened to 4
module vfbm_top_test;
   import vfbm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic        nc = 0, fault_i = 0, three_solenoid_i = 1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0, travel = 4'h1;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic [2:0]  keys = 3'h0;
   vfbm_cmd_t   cmd = '0, cmd_w;
   vfbm_seat_t  seat_w;
   wire logic [31:0] wb_dat_o;
   wire logic wb_ack_o, lift_w, fb0, fb1, fb2, fb3, vs, led8, irq_o;
   wire logic [4:0] fbv = {fb0, fb1, fb2, fb3, vs};
   int miscompares = 0, checks = 0, cycles = 0;
   localparam logic [2:0] CMDS [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
   localparam logic [4:0] DEF  [4] = '{5'h11, 5'h09, 5'h05, 5'h03};
   localparam logic [4:0] USM  [4] = '{5'h17, 5'h09, 5'h03, 5'h05};

   always #20 clk_i = ~clk_i;

   vfbm_plc vfbm_plc_i (.clk_i, .cmd_i(cmd), .nc_i(nc), .travel_i(travel), .cmd_o(cmd_w),
      .seat_o(seat_w), .lift_sense_o(lift_w));

   vfbm_top #(.FLASH_CYCLES(4)) vfbm_top_i (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .command_bit_one_i(cmd_w.main_solenoid), .command_bit_two_i(cmd_w.upper_lift_solenoid),
      .command_bit_three_i(cmd_w.lower_push_solenoid), .upper_closed_i(seat_w.upper_closed),
      .upper_lift_sense_i(lift_w), .lower_closed_i(seat_w.lower_closed),
      .lower_open_i(seat_w.lower_open), .lower_push_i(seat_w.lower_push), .fault_i,
      .three_solenoid_i, .select_key_i(keys[0]), .enter_key_i(keys[1]), .restore_i(keys[2]),
      .feedback_bit_zero_o(fb0), .feedback_bit_one_o(fb1), .feedback_bit_two_o(fb2),
      .feedback_bit_three_o(fb3), .valve_state_o(vs), .led8_flash_o(led8), .irq_o);

   task automatic close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // holds the request until ack is sampled high, as classic wishbone asks
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
      chk(32'(n >= 20), 32'h0);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask

   task automatic fbchk(input int i, input logic [4:0] e);
      cmd <= CMDS[i];
      wait_n(12 + int'(travel));
      chk({27'h0, fbv}, {27'h0, e});
   endtask

   task automatic press(input int k);
      keys[k] <= 1'b1;
      wait_n(4);
      keys[k] <= 1'b0;
      wait_n(4);
   endtask

   task automatic do_reset;
      sys_rst_i <= 1'b1;
      wait_n(5);
      sys_rst_i <= 1'b0;
      wait_n(1);
   endtask

   // ceiling sits far above the few hundred cycles the sequence needs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      do_reset();
      rdchk(CTRL_OFS, 32'h7, 32'h0);
      rdchk(STATUS_OFS, 32'h7ff, 32'h051);
      rdchk(8'h40, 32'hffffffff, 32'h0);
      for (int i = 0; i < 4; i++) fbchk(i, DEF[i]);
      travel <= 4'h9;
      for (int m = 1; m < 4; m += 2) begin
         wb(1'b1, CTRL_OFS, 32'(m));
         nc <= m[1];
         for (int i = 0; i < 4; i++) fbchk(i, USM[i]);
      end
      wb(1'b1, CTRL_OFS, 32'h0);
      nc <= 1'b0;
      travel <= 4'h1;
      fbchk(0, DEF[0]);
      for (int i = 0; i < 5; i++) press(0);
      for (int n = 0; n < 20 && led8 !== 1'b1; n++) @(posedge clk_i);
      chk({31'h0, led8}, 32'h1);
      press(1);
      rdchk(CTRL_OFS, 32'h1, 32'h1);
      wb(1'b1, CTRL_OFS, 32'h3);
      nc <= 1'b1;
      press(2);
      rdchk(CTRL_OFS, 32'h7, 32'h1);
      nc <= 1'b0;
      wb(1'b1, IRQ_MASK_OFS, 32'h2);
      fault_i <= 1'b1;
      wait_n(10);
      chk({30'h0, vs, irq_o}, 32'h1);
      fault_i <= 1'b0;
      wait_n(10);
      wb(1'b1, IRQ_STAT_OFS, 32'h2);
      wait_n(3);
      chk({30'h0, vs, irq_o}, 32'h2);
      wb(1'b1, CTRL_OFS, 32'h5);
      wait_n(6);
      chk({31'h0, vs}, 32'h0);
      three_solenoid_i <= 1'b0;
      do_reset();
      wb(1'b1, CTRL_OFS, 32'h1);
      fbchk(0, 5'h11);
      fbchk(1, 5'h09);
      rdchk(STATUS_OFS, 32'h60, 32'h0);
      close_out();
   end
endmodule
